//--- acxc_defines.svh
// Behaviour
// - Chop select 10 drives both phases and both complements on the four pins.
// - Chop select 11 drives only the two true phases; outside inverts.
// - Chop select zero produces no alternating drive.
// - Phase one drives pins 0 and 2 high, pins 1 and 3 low.
// - Phase two drives pins 0 and 2 low, pins 1 and 3 high.
// - Phase two conversion treats input and reference as inverted.
// - Results of both phases are averaged into one output.
// - Settling delay is inserted at the start of each phase.
// - In standby the general pins keep driving their configured states.
// - In power-down the general pin outputs are released.
// - After reset the pins are undriven until software configures them.
// - Bridge power switch is closed in normal operation.
// - Standby keep bit holds the bridge switch active in standby when bridge_power_switch_i is also set.
`ifndef ACXC_DEFINES_SVH
`define ACXC_DEFINES_SVH
`define ACXC_CHOP_OFF    2'b00
`define ACXC_CHOP_FULL   2'b10
`define ACXC_CHOP_TRUE   2'b11
`define ACXC_DATA_W      24
`define ACXC_DELAY_W     16
`define ACXC_PIN_N       4
`define ACXC_RST_DELAY   16'h0000
`endif

//--- acxc_pkg.sv
package acxc_pkg;
   typedef enum logic [1:0] {
      ACXC_PM_NORMAL,
      ACXC_PM_STANDBY,
      ACXC_PM_POWERDOWN,
      ACXC_PM_RSVD
   } acxc_pmode_t;
   typedef enum logic [1:0] {
      ACXC_ST_IDLE,
      ACXC_ST_SETTLE,
      ACXC_ST_CONVERT
   } acxc_state_t;
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } acxc_pins_t;
   typedef struct packed {
      logic        valid;
      logic [23:0] data;
   } acxc_sample_t;
endpackage

//--- acxc_avg.sv
`timescale 1ns/1ps
`include "acxc_defines.svh"
module acxc_avg #(
   parameter int DATA_W = `ACXC_DATA_W
) (
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   input  wire logic              clear_i,
   input  wire logic              load_a_i,
   input  wire logic              load_b_i,
   input  wire logic [DATA_W-1:0] data_i,
   output logic                   valid_o,
   output logic      [DATA_W-1:0] avg_o
);
   initial begin
      if (DATA_W < 2) $error("DATA_W too small");
   end
   typedef struct packed {
      logic [DATA_W-1:0] a;
      logic [DATA_W-1:0] avg;
      logic              valid;
   } acxc_avg_st_t;
   acxc_avg_st_t st_r;
   acxc_avg_st_t st_nxt;
   logic [DATA_W:0] sum;
   always_comb begin
      st_nxt = st_r;
      st_nxt.valid = 1'b0;
      // Phase two sample arrives inverted, so it is negated back
      sum = {st_r.a[DATA_W-1], st_r.a} - {data_i[DATA_W-1], data_i};
      if (clear_i) begin
         st_nxt.a = '0;
      end else if (load_a_i) begin
         st_nxt.a = data_i;
      end else if (load_b_i) begin
         st_nxt.avg = sum[DATA_W:1];
         st_nxt.valid = 1'b1;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign valid_o = st_r.valid;
   assign avg_o = st_r.avg;
endmodule

//--- acxc_ctrl.sv
`timescale 1ns/1ps
`include "acxc_defines.svh"
module acxc_ctrl
   import acxc_pkg::*;
#(
   parameter int DATA_W  = `ACXC_DATA_W,
   parameter int DELAY_W = `ACXC_DELAY_W
) (
   input  wire logic                  clk_sys_i,
   input  wire logic                  rst_n_i,
   input  wire logic [1:0]            excitation_chop_select_i,
   input  wire logic                  pins_configured_i,
   input  wire logic [3:0]            dc_pin_level_i,
   input  wire acxc_pmode_t           power_mode_i,
   input  wire logic                  bridge_power_switch_i,
   input  wire logic                  standby_bridge_switch_keep_i,
   input  wire logic [DELAY_W-1:0]    settle_delay_i,
   input  wire logic                  conv_done_i,
   input  wire logic [DATA_W-1:0]     conv_data_i,
   output acxc_pins_t                 general_io_o,
   output logic                       conv_start_o,
   output logic                       input_invert_o,
   output logic                       ref_invert_o,
   output logic                       bridge_switch_closed_o,
   output logic                       rdy_n_o,
   output logic [DATA_W-1:0]          result_o
);
   import acxc_pkg::*;
   initial begin
      if (DELAY_W < 1 || DATA_W < 2) $error("bad parameters");
   end
   typedef struct packed {
      acxc_state_t        state;
      logic               phase_two;
      logic [DELAY_W-1:0] cnt;
      acxc_pins_t         pins;
      logic               start;
      logic               inv;
      logic               sw;
      logic               rdy_n;
      logic [DATA_W-1:0]  result;
   } acxc_ctrl_st_t;
   acxc_ctrl_st_t st_r;
   acxc_ctrl_st_t st_nxt;
   logic              avg_valid;
   logic [DATA_W-1:0] avg_data;
   logic              chop_on;
   logic              load_a;
   logic              load_b;

   function automatic logic [3:0] phase_pins(input logic two);
      // Pins 0/2 on phase one, pins 1/3 on phase two
      phase_pins = two ? 4'b1010 : 4'b0101;
   endfunction

   assign chop_on = (excitation_chop_select_i == `ACXC_CHOP_FULL) ||
                    (excitation_chop_select_i == `ACXC_CHOP_TRUE);
   assign load_a = (st_r.state == ACXC_ST_CONVERT) && conv_done_i &&
                   !st_r.phase_two;
   assign load_b = (st_r.state == ACXC_ST_CONVERT) && conv_done_i &&
                   st_r.phase_two;

   acxc_avg #(
      .DATA_W (DATA_W)
   ) u_avg (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .clear_i   (!chop_on),
      .load_a_i  (load_a),
      .load_b_i  (load_b),
      .data_i    (conv_data_i),
      .valid_o   (avg_valid),
      .avg_o     (avg_data)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.start = 1'b0;
      case (st_r.state)
         ACXC_ST_IDLE: begin
            if (chop_on && power_mode_i != ACXC_PM_POWERDOWN) begin
               st_nxt.state = ACXC_ST_SETTLE;
               st_nxt.phase_two = 1'b0;
               st_nxt.cnt = settle_delay_i;
            end
         end
         ACXC_ST_SETTLE: begin
            if (!chop_on) begin
               st_nxt.state = ACXC_ST_IDLE;
            end else if (st_r.cnt == '0) begin
               st_nxt.state = ACXC_ST_CONVERT;
               st_nxt.start = 1'b1;
            end else begin
               st_nxt.cnt = st_r.cnt - 1'b1;
            end
         end
         ACXC_ST_CONVERT: begin
            if (!chop_on) begin
               st_nxt.state = ACXC_ST_IDLE;
            end else if (conv_done_i) begin
               st_nxt.phase_two = !st_r.phase_two;
               st_nxt.cnt = settle_delay_i;
               st_nxt.state = ACXC_ST_SETTLE;
            end
         end
         default: begin
            st_nxt.state = ACXC_ST_IDLE;
         end
      endcase
      st_nxt.inv = st_nxt.phase_two && chop_on;
      // Pin drive
      if (power_mode_i == ACXC_PM_POWERDOWN || !pins_configured_i) begin
         st_nxt.pins.oe = 4'b0000;
         st_nxt.pins.out = 4'b0000;
      end else if (excitation_chop_select_i == `ACXC_CHOP_FULL) begin
         st_nxt.pins.oe = 4'b1111;
         st_nxt.pins.out = phase_pins(st_nxt.phase_two);
      end else if (excitation_chop_select_i == `ACXC_CHOP_TRUE) begin
         st_nxt.pins.oe = 4'b0011;
         st_nxt.pins.out = {2'b00, st_nxt.phase_two, !st_nxt.phase_two};
      end else begin
         st_nxt.pins.oe = 4'b1111;
         st_nxt.pins.out = dc_pin_level_i;
      end
      case (power_mode_i)
         ACXC_PM_NORMAL: st_nxt.sw = 1'b1;
         ACXC_PM_STANDBY: st_nxt.sw = standby_bridge_switch_keep_i &&
                                      bridge_power_switch_i;
         default: st_nxt.sw = 1'b0;
      endcase
      if (avg_valid) begin
         st_nxt.result = avg_data;
         st_nxt.rdy_n = 1'b0;
      end else if (!chop_on && conv_done_i) begin
         st_nxt.result = conv_data_i;
         st_nxt.rdy_n = 1'b0;
      end else if (st_r.start) begin
         st_nxt.rdy_n = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
         st_r.rdy_n <= 1'b1;
         st_r.cnt <= DELAY_W'(`ACXC_RST_DELAY);
      end else begin
         st_r <= st_nxt;
      end
   end

   assign general_io_o = st_r.pins;
   assign conv_start_o = st_r.start;
   assign input_invert_o = st_r.inv;
   assign ref_invert_o = st_r.inv;
   assign bridge_switch_closed_o = st_r.sw;
   assign rdy_n_o = st_r.rdy_n;
   assign result_o = st_r.result;
endmodule

//--- acxc_checker.sv
`timescale 1ns/1ps
module acxc_checker (
   input wire logic                  clk_sys_i,
   input wire logic                  rst_n_i,
   input wire logic [1:0]            excitation_chop_select_i,
   input wire acxc_pkg::acxc_pmode_t power_mode_i,
   input wire logic                  bridge_power_switch_i,
   input wire logic                  standby_bridge_switch_keep_i,
   input wire acxc_pkg::acxc_pins_t  general_io_o,
   input wire logic                  conv_start_o,
   input wire logic                  input_invert_o,
   input wire logic                  ref_invert_o,
   input wire logic                  bridge_switch_closed_o,
   input wire logic                  rdy_n_o
);
   import acxc_pkg::*;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   wire logic [1:0] cs = excitation_chop_select_i;
   wire logic [3:0] oe = general_io_o.oe;
   wire logic       pd = power_mode_i == ACXC_PM_POWERDOWN;
   wire logic       sb = power_mode_i == ACXC_PM_STANDBY;
   a_full_phase: assert property ((cs == 2'b10)[*3] ##0 oe == 4'hf
      |-> general_io_o.out == (input_invert_o ? 4'ha : 4'h5)) else $error("phase");
   a_true_pins: assert property ((cs == 2'b11)[*3] ##0 oe != 4'h0
      |-> oe == 4'h3) else $error("true pins");
   a_inv_pair: assert property (input_invert_o == ref_invert_o)
      else $error("invert pair");
   a_settle_gap: assert property ($rose(input_invert_o)
      |-> !conv_start_o [*3]) else $error("settle");
   a_avg_after: assert property ($fell(rdy_n_o)
      |-> $past(input_invert_o, 2)) else $error("average");
   a_pd_release: assert property (pd [*2]
      |-> oe == 4'h0 && !bridge_switch_closed_o) else $error("powerdown");
   a_norm_closed: assert property ((power_mode_i == ACXC_PM_NORMAL)[*2]
      |-> bridge_switch_closed_o) else $error("switch open");
   a_stb_keep: assert property ((sb && standby_bridge_switch_keep_i
      && bridge_power_switch_i)[*2] |-> bridge_switch_closed_o) else $error("keep");
   c_rdy: cover property ($fell(rdy_n_o));
   c_phase2: cover property ($rose(input_invert_o));
   c_stb: cover property (sb && bridge_switch_closed_o);
endmodule
bind acxc_ctrl acxc_checker u_chk (.*);

//--- acxc_bridge_model.sv
`timescale 1ns/1ps
module acxc_bridge_model (
   input  wire logic                 clk_sys_i,
   input  wire acxc_pkg::acxc_pins_t pins_i,
   input  wire logic                 start_i,
   input  wire logic [3:0]           lat_i,
   output logic                      done_o,
   output logic [23:0]               data_o
);
   import acxc_pkg::*;
   logic [3:0]  cnt_r = 4'h0;
   logic [23:0] val_r = 24'h0;
   initial begin
      done_o = 1'b0;
      data_o = 24'h0;
   end
   always @(posedge clk_sys_i) begin
      done_o <= 1'b0;
      data_o <= ~data_o;
      if (start_i) begin
         cnt_r <= lat_i;
         // Pin 0 gives polarity; complements not needed
         val_r <= pins_i.out[0] ? 24'h00_1334 : 24'hff_eecc;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
         done_o <= cnt_r == 4'h1;
         data_o <= val_r;
      end
   end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import acxc_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [1:0]  chop = 2'b00;
   logic        cfg = 1'b0;
   logic        sw = 1'b1;
   logic        keep = 1'b0;
   logic [3:0]  lat = 4'h1;
   acxc_pmode_t pm = ACXC_PM_NORMAL;
   acxc_pins_t  pins;
   logic        done, start, inv, closed, rdy_n, ref_inv;
   logic [23:0] cdata, res;
   int          n_mismatch = 0;
   int          check_count = 0;
   acxc_ctrl dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .excitation_chop_select_i(chop), .pins_configured_i(cfg),
      .dc_pin_level_i(4'h9), .power_mode_i(pm), .bridge_power_switch_i(sw),
      .standby_bridge_switch_keep_i(keep), .settle_delay_i(16'h0003),
      .conv_done_i(done), .conv_data_i(cdata), .general_io_o(pins),
      .conv_start_o(start), .input_invert_o(inv), .ref_invert_o(ref_inv),
      .bridge_switch_closed_o(closed), .rdy_n_o(rdy_n), .result_o(res));
   acxc_bridge_model model (.clk_sys_i(clk_sys_i), .pins_i(pins),
      .start_i(start), .lat_i(lat), .done_o(done), .data_o(cdata));
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_rdy(input logic lvl);
      for (int i = 0; i < 300 && rdy_n !== lvl; i++) step(1);
      if (rdy_n !== lvl) begin
         n_mismatch++;
         results();
      end
   endtask
   task automatic t_reset;
      chk({20'h0, pins.oe}, 24'h0);
      rst_n_i = 1'b1;
      step(3);
      chk({20'h0, pins.oe}, 24'h0);
      $display("reset test done");
   endtask
   task automatic t_off;
      cfg = 1'b1;
      step(3);
      chk({16'h0, pins}, 24'h9f);
      chk({22'h0, inv, ref_inv}, 24'h0);
      $display("dc test done");
   endtask
   task automatic t_conv(input logic [1:0] mode);
      chop = mode;
      step(4);
      chk({20'h0, pins.oe}, mode[0] ? 24'h3 : 24'hf);
      wait_rdy(1'b1);
      wait_rdy(1'b0);
      chk(res, 24'h00_1234);
      lat = 4'h6;
      step(3);
      chk({22'h0, start, ref_inv}, 24'h2);
      wait_rdy(1'b1);
      wait_rdy(1'b0);
      chk(res, 24'h00_1234);
      lat = 4'h1;
      $display("chop test done");
   endtask
   task automatic t_power;
      pm = ACXC_PM_STANDBY;
      keep = 1'b1;
      step(3);
      chk({22'h0, closed, pins.oe[0]}, 24'h3);
      keep = 1'b0;
      step(3);
      chk({23'h0, closed}, 24'h0);
      pm = ACXC_PM_POWERDOWN;
      step(3);
      chk({19'h0, closed, pins.oe}, 24'h0);
      pm = ACXC_PM_NORMAL;
      step(3);
      chk({23'h0, closed}, 24'h1);
      $display("power test done");
   endtask
   initial begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      step(4);
      t_reset();
      t_off();
      t_conv(2'b10);
      t_conv(2'b11);
      t_power();
      results();
   end
endmodule
